// ===== rtl/icscr_pkg.sv
// Shared constants and types for the clock synthesizer serial configuration link
package icscr_pkg;

	// Seven-bit target address; with the write bit appended it reads as 8'hd2
	localparam logic [6:0] TARGET_ADDR = 7'h69;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;

	// Command code fields
	localparam int CMD_SINGLE_BIT = 7;
	localparam int CMD_CHIP_SEL_HI = 6;
	localparam int CMD_CHIP_SEL_LO = 5;
	localparam int CMD_OFS_HI = 4;
	localparam logic [1:0] CMD_CHIP_SEL_VAL = 2'h0;

	// Register byte offsets
	localparam logic [4:0] OFS_OUTPUT_ENABLE_CTRL = 5'h00;
	localparam logic [4:0] OFS_RESERVED_CTRL_A = 5'h01;
	localparam logic [4:0] OFS_SPREAD_SPECTRUM_CTRL = 5'h02;
	localparam logic [4:0] OFS_RESERVED_CTRL_B = 5'h03;
	localparam logic [4:0] OFS_RESERVED_CTRL_C = 5'h04;
	localparam logic [4:0] OFS_RESERVED_CTRL_D = 5'h05;
	localparam logic [4:0] OFS_TEST_CLOCK_CTRL = 5'h06;
	localparam logic [4:0] OFS_REVISION_VENDOR_IDENT = 5'h07;
	localparam int NUM_WRITABLE = 7;

	// Power-up values, reserved bits included
	localparam logic [7:0] RST_OUTPUT_ENABLE_CTRL = 8'h7c;
	localparam logic [7:0] RST_RESERVED_CTRL_A = 8'h00;
	localparam logic [7:0] RST_SPREAD_SPECTRUM_CTRL = 8'hea;
	localparam logic [7:0] RST_RESERVED_CTRL_B = 8'haf;
	localparam logic [7:0] RST_RESERVED_CTRL_C = 8'h01;
	localparam logic [7:0] RST_RESERVED_CTRL_D = 8'h00;
	localparam logic [7:0] RST_TEST_CLOCK_CTRL = 8'h13;

	// Field positions
	localparam int OUTPUT_PAIR_TWO_BIT = 4;
	localparam int OUTPUT_PAIR_ONE_BIT = 3;
	localparam int SPREAD_DEPTH_BIT = 7;
	localparam int SPREAD_ENABLE_BIT = 2;
	localparam int TEST_OUTPUT_SEL_BIT = 7;
	localparam int TEST_CLOCK_MODE_BIT = 6;

	// Controller register map (byte addresses on the AHB-Lite side)
	localparam logic [31:0] HOST_CMD_ADDR = 32'h0000_0000;
	localparam logic [31:0] HOST_STATUS_ADDR = 32'h0000_0004;
	localparam int HCMD_WDATA_LO = 0;
	localparam int HCMD_OFS_LO = 8;
	localparam int HCMD_READ_BIT = 16;
	localparam int HSTAT_BUSY_BIT = 0;
	localparam int HSTAT_DONE_BIT = 1;
	localparam int HSTAT_NACK_BIT = 2;
	localparam int HSTAT_RDATA_LO = 8;

	// Serial timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [7:0] {
		DEV_IDLE = 8'h01,
		DEV_ADDR = 8'h02,
		DEV_CMD = 8'h04,
		DEV_WDATA = 8'h08,
		DEV_ACK = 8'h10,
		DEV_RDATA = 8'h20,
		DEV_MACK = 8'h40,
		DEV_IGNORE = 8'h80
	} icscr_dev_state_t;

	typedef enum logic [3:0] {
		HST_IDLE = 4'h1,
		HST_START = 4'h2,
		HST_BYTE = 4'h4,
		HST_STOP = 4'h8
	} icscr_host_state_t;

	function automatic logic [7:0] icscr_reset_value(input logic [2:0] idx);
		case (idx)
			3'h0: icscr_reset_value = RST_OUTPUT_ENABLE_CTRL;
			3'h1: icscr_reset_value = RST_RESERVED_CTRL_A;
			3'h2: icscr_reset_value = RST_SPREAD_SPECTRUM_CTRL;
			3'h3: icscr_reset_value = RST_RESERVED_CTRL_B;
			3'h4: icscr_reset_value = RST_RESERVED_CTRL_C;
			3'h5: icscr_reset_value = RST_RESERVED_CTRL_D;
			default: icscr_reset_value = RST_TEST_CLOCK_CTRL;
		endcase
	endfunction

endpackage

// ===== rtl/icscr_if.sv
// Two-wire link between controller and target with open-drain resolution
`timescale 1ns/1ns
interface icscr_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic serial_data_pin;

	// Wired-AND with pull-ups: low whenever any end drives a zero
	assign scl = !(host_scl_oe && !host_scl_o);
	assign serial_data_pin = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input scl,
		input serial_data_pin
	);

	modport device (
		output dev_sda_o,
		output dev_sda_oe,
		input scl,
		input serial_data_pin
	);
endinterface

// ===== rtl/icscr_cond_det.sv
// Line event detector: clock edges, start and stop conditions
`timescale 1ns/1ns
module icscr_cond_det (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic scl, // serial clock level
	input wire logic sda, // serial data level
	output logic scl_rise, // clock rose, one cycle
	output logic scl_fall, // clock fell, one cycle
	output logic start_seen, // start or repeated start, one cycle
	output logic stop_seen, // stop, one cycle
	output logic sda_now // registered data level
);
	logic scl_q;
	logic sda_q;
	logic scl_qq;
	logic sda_qq;
	logic [1:0] next_scl_pipe;
	logic [1:0] next_sda_pipe;

	always_comb begin
		next_scl_pipe = {scl_q, scl};
		next_sda_pipe = {sda_q, sda};
	end

	// Idle level of both lines is high, so reset to one avoids false events
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_qq <= 1'b1;
			sda_qq <= 1'b1;
		end else begin
			{scl_qq, scl_q} <= next_scl_pipe;
			{sda_qq, sda_q} <= next_sda_pipe;
		end
	end

	assign scl_rise = scl_q && !scl_qq;
	assign scl_fall = !scl_q && scl_qq;
	assign start_seen = scl_q && scl_qq && !sda_q && sda_qq;
	assign stop_seen = scl_q && scl_qq && sda_q && !sda_qq;
	assign sda_now = sda_q;
endmodule

// ===== rtl/icscr_device.sv
// Serial target with the eight configuration register bytes
`timescale 1ns/1ns
// Overview of operation
// - Start, address plus write, acked slot nine
// - Command byte slots ten-seventeen, acked eighteen
// - Write data byte acked, then stop
// - Repeated start, address plus read, acked
// - Target sends byte; controller nacks, stops
// - Byte zero bits four, three: pair enables
// - Byte two spread depth select, default one
// - Byte two spread enable, default off
// - Byte six bit six: test clock mode
// - Byte six bit seven: test output select
// - Byte seven: fixed revision and vendor
// - Reset loads every byte's power-up value
// - Respond only to address 7'h69: write always, read only after a command
// - Command bit seven single, low bits offset
// - Command bits six, five must be zero
module icscr_device import icscr_pkg::*; #(
	parameter logic [3:0] REVISION_CODE = 4'h5, // arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'ha // arbitrary value
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	icscr_if.device link, // serial link
	output logic output_pair_one_enable, // pair one on when high
	output logic output_pair_two_enable, // pair two on when high
	output logic spread_depth_select, // 0: -0.35%, 1: -0.5%
	output logic spread_modulation_enable, // spread on when high
	output logic test_clock_mode, // test clock mode when high
	output logic test_output_select // in test mode 0: off, 1: divided ref
);
	icscr_dev_state_t state;
	icscr_dev_state_t next_state;
	icscr_dev_state_t after_ack;
	icscr_dev_state_t next_after_ack;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [4:0] reg_ofs;
	logic [4:0] next_reg_ofs;
	logic have_cmd;
	logic next_have_cmd;
	logic sda_oe;
	logic next_sda_oe;
	logic [7:0] cfg [NUM_WRITABLE];
	logic [7:0] next_cfg [NUM_WRITABLE];
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic sda_now;

	icscr_cond_det u_cond (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.scl(link.scl),
		.sda(link.serial_data_pin),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.sda_now(sda_now)
	);

	// Read mux; offsets past the map read as zero
	function automatic logic [7:0] read_byte(input logic [4:0] ofs,
			input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2,
			input logic [7:0] c3, input logic [7:0] c4, input logic [7:0] c5,
			input logic [7:0] c6);
		case (ofs)
			OFS_OUTPUT_ENABLE_CTRL: read_byte = c0;
			OFS_RESERVED_CTRL_A: read_byte = c1;
			OFS_SPREAD_SPECTRUM_CTRL: read_byte = c2;
			OFS_RESERVED_CTRL_B: read_byte = c3;
			OFS_RESERVED_CTRL_C: read_byte = c4;
			OFS_RESERVED_CTRL_D: read_byte = c5;
			OFS_TEST_CLOCK_CTRL: read_byte = c6;
			OFS_REVISION_VENDOR_IDENT: read_byte = {REVISION_CODE, VENDOR_CODE};
			default: read_byte = 8'h00;
		endcase
	endfunction

	always_comb begin
		next_state = state;
		next_after_ack = after_ack;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_reg_ofs = reg_ofs;
		next_have_cmd = have_cmd;
		next_cfg = cfg;
		if (stop_seen) begin
			next_state = DEV_IDLE;
			next_have_cmd = 1'b0;
		end else if (start_seen) begin
			// Covers repeated start in the middle of a read sequence
			next_state = DEV_ADDR;
			next_bit_cnt = 4'h0;
		end else begin
			unique case (state)
				DEV_IDLE, DEV_IGNORE: begin
				end
				DEV_ADDR, DEV_CMD, DEV_WDATA: begin
					if (scl_rise && bit_cnt < 4'h8) begin
						next_shreg = {shreg[6:0], sda_now};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						next_state = DEV_IGNORE;
						if (state == DEV_ADDR && shreg[7:1] == TARGET_ADDR) begin
							if (shreg[0] == RW_WRITE) begin
								next_state = DEV_ACK;
								next_after_ack = DEV_CMD;
							end else if (have_cmd) begin
								next_state = DEV_ACK;
								next_after_ack = DEV_RDATA;
							end
						end else if (state == DEV_CMD && shreg[CMD_SINGLE_BIT]
								&& shreg[CMD_CHIP_SEL_HI:CMD_CHIP_SEL_LO]
								== CMD_CHIP_SEL_VAL) begin
							next_state = DEV_ACK;
							next_after_ack = DEV_WDATA;
							next_reg_ofs = shreg[CMD_OFS_HI:0];
							next_have_cmd = 1'b1;
						end else if (state == DEV_WDATA) begin
							// Identity byte and unmapped offsets are acked but not stored
							if (reg_ofs < 5'(NUM_WRITABLE)) begin
								next_cfg[reg_ofs[2:0]] = shreg;
							end
							next_state = DEV_ACK;
							next_after_ack = DEV_IGNORE;
						end
					end
				end
				DEV_ACK: begin
					if (scl_fall) begin
						next_state = after_ack;
						next_bit_cnt = 4'h0;
						if (after_ack == DEV_RDATA) begin
							next_shreg = read_byte(reg_ofs, cfg[0], cfg[1], cfg[2], cfg[3],
								cfg[4], cfg[5], cfg[6]);
						end
					end
				end
				DEV_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							next_state = DEV_MACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b1};
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				DEV_MACK: begin
					// Single byte only: whatever the controller answers, wait for stop
					if (scl_fall) begin
						next_state = DEV_IGNORE;
					end
				end
				default: begin
					next_state = DEV_IDLE;
				end
			endcase
		end
		// Pull low only for ack or a zero data bit; a one is left to the pull-up
		next_sda_oe = (next_state == DEV_ACK)
			|| (next_state == DEV_RDATA && !next_shreg[7]);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= DEV_IDLE;
			after_ack <= DEV_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			reg_ofs <= 5'h00;
			have_cmd <= 1'b0;
			sda_oe <= 1'b0;
			for (int i = 0; i < NUM_WRITABLE; i++) begin
				cfg[i] <= icscr_reset_value(3'(i));
			end
		end else begin
			state <= next_state;
			after_ack <= next_after_ack;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			reg_ofs <= next_reg_ofs;
			have_cmd <= next_have_cmd;
			sda_oe <= next_sda_oe;
			cfg <= next_cfg;
		end
	end

	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe;

	assign output_pair_two_enable = cfg[OFS_OUTPUT_ENABLE_CTRL[2:0]][OUTPUT_PAIR_TWO_BIT];
	assign output_pair_one_enable = cfg[OFS_OUTPUT_ENABLE_CTRL[2:0]][OUTPUT_PAIR_ONE_BIT];
	assign spread_depth_select = cfg[OFS_SPREAD_SPECTRUM_CTRL[2:0]][SPREAD_DEPTH_BIT];
	assign spread_modulation_enable = cfg[OFS_SPREAD_SPECTRUM_CTRL[2:0]][SPREAD_ENABLE_BIT];
	assign test_clock_mode = cfg[OFS_TEST_CLOCK_CTRL[2:0]][TEST_CLOCK_MODE_BIT];
	assign test_output_select = cfg[OFS_TEST_CLOCK_CTRL[2:0]][TEST_OUTPUT_SEL_BIT];
endmodule

// ===== rtl/icscr_host.sv
// Serial bus controller driven from AHB-Lite command and status registers
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module icscr_host import icscr_pkg::*; #(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC // system clocks per quarter bit
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // response, always OKAY
	output logic [31:0] hrdata, // read data
	icscr_if.host link // serial link
);
	icscr_host_state_t state;
	icscr_host_state_t next_state;
	logic [15:0] qcnt;
	logic [15:0] next_qcnt;
	logic [1:0] ph;
	logic [1:0] next_ph;
	logic [3:0] bitn;
	logic [3:0] next_bitn;
	logic [2:0] step;
	logic [2:0] next_step;
	logic [7:0] txb;
	logic [7:0] next_txb;
	logic [7:0] rxb;
	logic [7:0] next_rxb;
	logic ack_bit;
	logic next_ack_bit;
	logic is_read;
	logic next_is_read;
	logic [4:0] ofs;
	logic [4:0] next_ofs;
	logic [7:0] wdat;
	logic [7:0] next_wdat;
	logic done;
	logic next_done;
	logic nack;
	logic next_nack;
	logic scl_oe;
	logic next_scl_oe;
	logic sda_oe;
	logic next_sda_oe;
	logic dp_write;
	logic [31:0] dp_addr;
	logic [31:0] next_hrdata;
	logic accept;
	logic qend;
	logic rx_byte;

	assign accept = hsel && hready && htrans[1];
	assign qend = (qcnt == 16'(QUARTER_CYC - 1));
	assign rx_byte = (step == 3'h4);

	always_comb begin
		next_state = state;
		next_qcnt = qcnt;
		next_ph = ph;
		next_bitn = bitn;
		next_step = step;
		next_txb = txb;
		next_rxb = rxb;
		next_ack_bit = ack_bit;
		next_is_read = is_read;
		next_ofs = ofs;
		next_wdat = wdat;
		next_done = done;
		next_nack = nack;
		next_hrdata = hrdata;
		if (accept && !hwrite) begin
			next_hrdata = 32'h0000_0000;
			if (haddr == HOST_STATUS_ADDR) begin
				next_hrdata[HSTAT_BUSY_BIT] = (state != HST_IDLE);
				next_hrdata[HSTAT_DONE_BIT] = done;
				next_hrdata[HSTAT_NACK_BIT] = nack;
				next_hrdata[HSTAT_RDATA_LO +: 8] = rxb;
			end
		end
		if (state == HST_IDLE) begin
			// Commands arriving while busy are dropped
			if (dp_write && dp_addr == HOST_CMD_ADDR) begin
				next_wdat = hwdata[HCMD_WDATA_LO +: 8];
				next_ofs = hwdata[HCMD_OFS_LO +: 5];
				next_is_read = hwdata[HCMD_READ_BIT];
				next_step = 3'h0;
				next_qcnt = 16'h0000;
				next_ph = 2'h0;
				next_done = 1'b0;
				next_nack = 1'b0;
				next_state = HST_START;
			end
		end else begin
			next_qcnt = qend ? 16'h0000 : qcnt + 16'h0001;
			if (qend) begin
				next_ph = ph + 2'h1;
				if (state == HST_BYTE && ph == 2'h2) begin
					if (bitn == 4'h8) begin
						next_ack_bit = link.serial_data_pin;
					end else begin
						next_rxb = {rxb[6:0], link.serial_data_pin};
					end
				end
				if (ph == 2'h3) begin
					unique case (state)
						HST_START: begin
							next_state = HST_BYTE;
							next_bitn = 4'h0;
							next_txb = {TARGET_ADDR, (step == 3'h0) ? RW_WRITE : RW_READ};
						end
						HST_BYTE: begin
							next_bitn = 4'h0;
							if (bitn != 4'h8) begin
								next_bitn = bitn + 4'h1;
							end else if (!rx_byte && ack_bit) begin
								next_nack = 1'b1;
								next_state = HST_STOP;
							end else if (step == 3'h0) begin
								next_step = 3'h1;
								next_txb = {1'b1, CMD_CHIP_SEL_VAL, ofs};
							end else if (step == 3'h1 && is_read) begin
								next_step = 3'h3;
								next_state = HST_START;
							end else if (step == 3'h1) begin
								next_step = 3'h2;
								next_txb = wdat;
							end else if (step == 3'h3) begin
								next_step = 3'h4;
							end else begin
								next_state = HST_STOP;
							end
						end
						HST_STOP: begin
							next_state = HST_IDLE;
							next_done = 1'b1;
						end
						default: begin
							next_state = HST_IDLE;
						end
					endcase
				end
			end
		end
		// Line levels per quarter; the read data byte ends in a released nack
		next_scl_oe = 1'b0;
		next_sda_oe = 1'b0;
		unique case (state)
			HST_IDLE: begin
			end
			HST_START: begin
				next_scl_oe = (ph == 2'h0) || (ph == 2'h3);
				next_sda_oe = ph[1];
			end
			HST_BYTE: begin
				next_scl_oe = (ph == 2'h0) || (ph == 2'h3);
				next_sda_oe = (bitn != 4'h8) && !rx_byte && !txb[3'(4'h7 - bitn)];
			end
			HST_STOP: begin
				next_scl_oe = (ph == 2'h0);
				next_sda_oe = !ph[1];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= HST_IDLE;
			qcnt <= 16'h0000;
			ph <= 2'h0;
			bitn <= 4'h0;
			step <= 3'h0;
			txb <= 8'h00;
			rxb <= 8'h00;
			ack_bit <= 1'b1;
			is_read <= 1'b0;
			ofs <= 5'h00;
			wdat <= 8'h00;
			done <= 1'b0;
			nack <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			qcnt <= next_qcnt;
			ph <= next_ph;
			bitn <= next_bitn;
			step <= next_step;
			txb <= next_txb;
			rxb <= next_rxb;
			ack_bit <= next_ack_bit;
			is_read <= next_is_read;
			ofs <= next_ofs;
			wdat <= next_wdat;
			done <= next_done;
			nack <= next_nack;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			dp_write <= accept && hwrite;
			dp_addr <= haddr;
			hrdata <= next_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_oe;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_oe;
endmodule

// ===== test/icscr_props.sv
// Wire-level checks on the controller-to-target serial link
`timescale 1ns/1ns
module icscr_props #(
	parameter int QUARTER_CYC = 4 // clocks per quarter bit
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic host_scl_oe, // host pulls clock low
	input wire logic host_sda_oe, // host pulls data low
	input wire logic dev_sda_oe, // target pulls data low
	input wire logic scl, // resolved clock
	input wire logic serial_data_pin // resolved data
);
	localparam int LOW_MAX = 4 * QUARTER_CYC;
	localparam int HOLD_MAX = 40 * QUARTER_CYC;
	logic scl_q, sda_q, in_frame, next_in_frame;
	logic start_ev, stop_ev;
	logic [7:0] rises, next_rises;

	assign start_ev = scl && scl_q && sda_q && !serial_data_pin;
	assign stop_ev = scl && scl_q && !sda_q && serial_data_pin;

	// Clock rises counted from the last start, so bit slots are known
	always_comb begin
		next_in_frame = start_ev ? 1'b1 : (stop_ev ? 1'b0 : in_frame);
		next_rises = start_ev ? 8'h00 : rises + {7'h00, scl && !scl_q};
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_frame <= 1'b0;
			rises <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= serial_data_pin;
			in_frame <= next_in_frame;
			rises <= next_rises;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_lines_released: assert property (
		$rose(rst_n) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("link not released after reset");
	chk_dev_scl_low: assert property (
		$changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("target changed data while clock high");
	// Target may pull low before the host lets go of its last bit; both low is harmless
	chk_ack_slot: assert property (
		$rose(dev_sda_oe) |-> rises inside {[8:17], 26})
		else $error("target drove data outside its slots");
	chk_no_contention: assert property (
		dev_sda_oe && scl |-> !host_sda_oe)
		else $error("host and target both drove data with clock high");
	chk_frame_only: assert property (
		dev_sda_oe |-> in_frame)
		else $error("target drove data outside a frame");
	chk_stop_slot: assert property (
		stop_ev |-> (rises % 9) == 1)
		else $error("stop not after a whole number of bytes");
	chk_scl_low_max: assert property (
		$fell(scl) |-> ##[1:LOW_MAX] scl)
		else $error("clock held low too long");
	chk_scl_high_max: assert property (
		in_frame && $rose(scl) |-> ##[1:LOW_MAX] (!scl || !in_frame))
		else $error("clock high too long in a frame");
	chk_dev_release: assert property (
		$rose(dev_sda_oe) |-> ##[1:HOLD_MAX] !dev_sda_oe)
		else $error("target never released data");
endmodule

// ===== test/tb_top.sv
// Bench: AHB-Lite controller and target on one link, a bit-banged link for faults
`timescale 1ns/1ns
module tb_top import icscr_pkg::*;;
	localparam int QC = 4;
	localparam logic [7:0] PUP [8] = '{8'h7c, 8'h00, 8'hea, 8'haf, 8'h01, 8'h00, 8'h13, 8'h69};
	localparam logic [4:0] W_OFS [6] = '{5'h00, 5'h02, 5'h06, 5'h03, 5'h01, 5'h07};
	localparam logic [7:0] W_VAL [6] = '{8'h6c, 8'h6e, 8'h53, 8'h50, 8'ha5, 8'hff};
	localparam logic [7:0] W_EXP [6] = '{8'h6c, 8'h6e, 8'h53, 8'h50, 8'ha5, 8'h69};
	localparam logic [6:0] B_ADR [4] = '{7'h6a, 7'h69, 7'h69, 7'h69};
	localparam logic [7:0] B_CMD [4] = '{8'h82, 8'h02, 8'ha2, 8'h82};
	localparam logic [2:0] B_ACK [4] = '{3'h0, 3'h4, 3'h4, 3'h7};
	localparam logic B_SPR [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic clk_sys, rst_n, hsel, hwrite, hready, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize, acks;
	logic [31:0] haddr, hwdata, hrdata, st;
	logic pair1, pair2, depth, spread, tmode, tsel, spread_b;
	logic [7:0] rb;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	icscr_if link_a();
	icscr_if link_b();
	assign link_b.host_scl_o = 1'b0;
	assign link_b.host_sda_o = 1'b0;

	icscr_host #(.QUARTER_CYC(QC)) icscr_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link_a.host));
	// Identity codes are arbitrary
	icscr_device #(.REVISION_CODE(4'h6), .VENDOR_CODE(4'h9)) icscr_device_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(link_a.device), .output_pair_one_enable(pair1),
		.output_pair_two_enable(pair2), .spread_depth_select(depth),
		.spread_modulation_enable(spread), .test_clock_mode(tmode), .test_output_select(tsel));
	icscr_device #(.REVISION_CODE(4'h6), .VENDOR_CODE(4'h9)) icscr_device_inst2 (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(link_b.device), .output_pair_one_enable(),
		.output_pair_two_enable(), .spread_depth_select(), .spread_modulation_enable(spread_b),
		.test_clock_mode(), .test_output_select());
	icscr_props #(.QUARTER_CYC(QC)) icscr_props_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.host_scl_oe(link_a.host_scl_oe), .host_sda_oe(link_a.host_sda_oe),
		.dev_sda_oe(link_a.dev_sda_oe), .scl(link_a.scl), .serial_data_pin(link_a.serial_data_pin));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Roughly four times the expected run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// One serial transfer through the controller, then poll until done
	task automatic dev_op(input logic rd, input logic [4:0] ofs, input logic [7:0] wd,
		output logic [7:0] rbyte);
		logic [31:0] s;
		ahb_xfer(1'b1, HOST_CMD_ADDR, {15'h0000, rd, 3'h0, ofs, wd}, s);
		s = 32'h0;
		while (s[HSTAT_DONE_BIT] !== 1'b1)
			ahb_xfer(1'b0, HOST_STATUS_ADDR, 32'h0, s);
		cmp_bit("nack", 1'b0, s[HSTAT_NACK_BIT]);
		cmp_bit("busy", 1'b0, s[HSTAT_BUSY_BIT]);
		rbyte = s[HSTAT_RDATA_LO +: 8];
	endtask

	task automatic bb_q(input logic c, input logic d);
		link_b.host_scl_oe <= !c;
		link_b.host_sda_oe <= !d;
		repeat (QC) @(posedge clk_sys);
	endtask

	// Eight bits out, then the ack slot with data released
	task automatic bb_byte(input logic [7:0] b, output logic ok);
		logic [8:0] s;
		s = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			bb_q(1'b0, s[i]);
			bb_q(1'b1, s[i]);
			bb_q(1'b1, s[i]);
			ok = !link_b.serial_data_pin;
			bb_q(1'b0, s[i]);
		end
	endtask

	task automatic bb_frame(input logic [6:0] a, input logic [7:0] cmd, output logic [2:0] ak);
		bb_q(1'b1, 1'b1);
		bb_q(1'b1, 1'b0);
		bb_q(1'b0, 1'b0);
		bb_byte({a, 1'b0}, ak[2]);
		bb_byte(cmd, ak[1]);
		bb_byte(8'h6e, ak[0]);
		bb_q(1'b0, 1'b0);
		bb_q(1'b1, 1'b0);
		bb_q(1'b1, 1'b1);
	endtask

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		link_b.host_scl_oe = 1'b0;
		link_b.host_sda_oe = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			dev_op(1'b1, 5'(i), 8'h00, rb);
			cmp_byte("power_up", PUP[i], rb);
		end
		cmp_bit("pair_one", 1'b1, pair1);
		cmp_bit("pair_two", 1'b1, pair2);
		cmp_bit("depth", 1'b1, depth);
		cmp_bit("spread", 1'b0, spread);
		cmp_bit("test_mode", 1'b0, tmode);
		cmp_bit("test_sel", 1'b0, tsel);
		foreach (W_OFS[i]) begin
			dev_op(1'b0, W_OFS[i], W_VAL[i], rb);
			dev_op(1'b1, W_OFS[i], 8'h00, rb);
			cmp_byte("readback", W_EXP[i], rb);
		end
		cmp_bit("pair_one", 1'b1, pair1);
		cmp_bit("pair_two", 1'b0, pair2);
		cmp_bit("depth", 1'b0, depth);
		cmp_bit("spread", 1'b1, spread);
		cmp_bit("test_mode", 1'b1, tmode);
		cmp_bit("test_sel", 1'b0, tsel);
		dev_op(1'b0, 5'h06, 8'h93, rb);
		cmp_bit("test_mode", 1'b0, tmode);
		cmp_bit("test_sel", 1'b1, tsel);
		dev_op(1'b1, 5'h08, 8'h00, rb);
		cmp_byte("past_end", 8'h00, rb);
		ahb_xfer(1'b0, 32'h0000_0010, 32'h0, st);
		cmp_byte("unmapped", 8'h00, st[7:0]);
		cmp_bit("hresp", 1'b0, hresp);
		foreach (B_ADR[i]) begin
			bb_frame(B_ADR[i], B_CMD[i], acks);
			cmp_byte("acks", {5'h00, B_ACK[i]}, {5'h00, acks});
			cmp_bit("spread_b", B_SPR[i], spread_b);
		end
		give_verdict();
	end
endmodule
